// ==== hw/p7io_cfg.svh ====
// Purpose: offsets, reset values and field positions for the port block
// Assumes: APB byte address is four times the register index
// Notes:   the latch index is not word aligned, so every index is scaled
`ifndef P7IO_CFG_SVH
`define P7IO_CFG_SVH
`define P7IO_IDX_DIR     16'hFFBC
`define P7IO_IDX_LATCH   16'hFFBE
`define P7IO_IDX_PULLUP  16'hFFF2
`define P7IO_IDX_CTRL    16'hFFC4
`define P7IO_IDX_STAT    16'hFFC8
`define P7IO_OFF_DIR     18'h3FEF0
`define P7IO_OFF_LATCH   18'h3FEF8
`define P7IO_OFF_PULLUP  18'h3FFC8
`define P7IO_OFF_CTRL    18'h3FF10
`define P7IO_OFF_STAT    18'h3FF20
`define P7IO_RST_DIR     8'h00
`define P7IO_RST_LATCH   8'h00
`define P7IO_RST_PULLUP  8'h00
`define P7IO_RST_KEYMASK 4'hF
`define P7IO_RST_NDIR0   1'b0
`define P7IO_RST_NLATCH0 1'b0
`define P7IO_CTRL_NDIR   0
`define P7IO_CTRL_NLAT   1
`define P7IO_CTRL_KM_LO  4
`define P7IO_CTRL_KM_HI  7
`define P7IO_RD_ONES     8'hFF
`endif

// ==== hw/p7io_pkg.sv ====
// Purpose: types shared by the port block
// Assumes: nothing beyond the config header
// Notes:   mode selects which pins a bus or host function takes over
package p7io_pkg;
  typedef enum logic [1:0] {
    P7IO_MODE_1,
    P7IO_MODE_2,
    P7IO_MODE_3
  } p7io_mode_t;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pullup_on;
  } p7io_pads_t;

  typedef enum logic [1:0] {
    P7IO_IDLE,
    P7IO_ACCESS
  } p7io_bus_state_t;
endpackage

// ==== hw/p7io_port.sv ====
// Purpose: 8-bit port with direction, latch, pull-ups and pin sharing
// Assumes: APB slave on pclk, one wait state, presetn async low
// Notes:   hw standby clears like reset, sw standby keeps everything
//
// What this block does
// - neighbour pin 0 input or output by direction
// - timer clock only when external source selected
// - direction bit 1 output, 0 input
// - direction register write-only, reads all ones
// - reset, hw standby clear direction; sw keeps
// - output pins read back latch value
// - input pins read sampled pin level
// - latch cleared by reset/hw standby, kept otherwise
// - key mask 0 routes pins 3..0 upward
// - mask bit 7 set reads one
// - pull-up only on input with enable set
// - pull-up bits 7..4 for pins 3..0 here, bit 0 for neighbour pin 0
// - pull-up register read/write, cleared like others
// - pin 7 wait, GPIO or host address
// - pins 6,5 strobes, GPIO or host strobes
`timescale 1ns/10ps
`include "p7io_cfg.svh"
module p7io_port
  import p7io_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_standby,
  input  wire p7io_mode_t  op_mode,
  input  wire logic        slave_mode,
  input  wire logic        wait_pin_used,
  input  wire logic        bus_rd_strobe_n,
  input  wire logic        bus_wr_strobe_n,
  input  wire logic        timer_clock_select_hi,
  input  wire logic        timer_clock_select_lo,
  input  wire logic [7:0]  pin_in,
  input  wire logic [3:0]  neighbour_pin_in,
  input  wire logic        neighbour_pin0_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pullup_on,
  output logic      [3:0]  neighbour_pullup_on,
  output logic             neighbour_pin0_out,
  output logic             neighbour_pin0_oe,
  output logic      [7:0]  neighbour_read_hi,
  output logic             bus_wait_in,
  output logic             host_addr_bit,
  output logic             host_read_strobe,
  output logic             host_write_strobe,
  output logic             timer_ext_clock_in,
  output logic             key_sense_in
);
  logic [7:0] pin_direction_bits_q;
  logic [7:0] output_latch_q;
  logic [7:0] pullup_enable_bits_q;
  logic [3:0] key_mask_select_q;
  logic       neighbour_direction_bits_q;
  logic       neighbour_latch_q;
  logic [7:0] sync1_q, sync2_q, sync3_q, pin_lvl_q;
  logic [4:0] nsync1_q, nsync2_q, nsync3_q, nlvl_q;
  logic [7:0] taken;
  logic [7:0] eff_oe;
  logic [7:0] eff_out;
  logic [7:0] read_mux;
  logic [31:0] rdata_d;
  logic       clr;
  logic       wr_en;
  logic       ext_clk_sel;

  assign clr   = hw_standby;
  // write lands only at the edge that completes the transfer
  assign wr_en = psel && penable && pwrite && pready;
  assign ext_clk_sel = timer_clock_select_hi && timer_clock_select_lo;

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q   <= 8'h00;
      sync2_q   <= 8'h00;
      sync3_q   <= 8'h00;
      pin_lvl_q <= 8'h00;
      nsync1_q  <= 5'h00;
      nsync2_q  <= 5'h00;
      nsync3_q  <= 5'h00;
      nlvl_q    <= 5'h00;
    end else begin
      sync1_q  <= pin_in;
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      nsync1_q <= {neighbour_pin_in, neighbour_pin0_in};
      nsync2_q <= nsync1_q;
      nsync3_q <= nsync2_q;
      for (int i = 0; i < 8; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_lvl_q[i] <= sync3_q[i];
        end
      end
      for (int j = 0; j < 5; j++) begin
        if (nsync2_q[j] == nsync3_q[j]) begin
          nlvl_q[j] <= nsync3_q[j];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bits_q <= `P7IO_RST_DIR;
    end else if (clr) begin
      pin_direction_bits_q <= `P7IO_RST_DIR;
    end else if (wr_en && paddr == `P7IO_OFF_DIR) begin
      pin_direction_bits_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_latch_q <= `P7IO_RST_LATCH;
    end else if (clr) begin
      output_latch_q <= `P7IO_RST_LATCH;
    end else if (wr_en && paddr == `P7IO_OFF_LATCH) begin
      output_latch_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_enable_bits_q <= `P7IO_RST_PULLUP;
    end else if (clr) begin
      pullup_enable_bits_q <= `P7IO_RST_PULLUP;
    end else if (wr_en && paddr == `P7IO_OFF_PULLUP) begin
      pullup_enable_bits_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_mask_select_q          <= `P7IO_RST_KEYMASK;
      neighbour_direction_bits_q <= `P7IO_RST_NDIR0;
      neighbour_latch_q          <= `P7IO_RST_NLATCH0;
    end else if (clr) begin
      key_mask_select_q          <= `P7IO_RST_KEYMASK;
      neighbour_direction_bits_q <= `P7IO_RST_NDIR0;
      neighbour_latch_q          <= `P7IO_RST_NLATCH0;
    end else if (wr_en && paddr == `P7IO_OFF_CTRL) begin
      key_mask_select_q <= pwdata[`P7IO_CTRL_KM_HI:`P7IO_CTRL_KM_LO];
      neighbour_direction_bits_q <= pwdata[`P7IO_CTRL_NDIR];
      neighbour_latch_q          <= pwdata[`P7IO_CTRL_NLAT];
    end
  end

  // pins taken by a mode function ignore direction and latch
  always_comb begin
    taken = 8'h00;
    eff_out = output_latch_q;
    if (op_mode != P7IO_MODE_3) begin
      taken[7] = wait_pin_used;
      taken[6] = 1'b1;
      taken[5] = 1'b1;
      eff_out[6] = bus_rd_strobe_n;
      eff_out[5] = bus_wr_strobe_n;
    end else if (slave_mode) begin
      taken[7] = 1'b1;
      taken[6] = 1'b1;
      taken[5] = 1'b1;
    end
    eff_oe = pin_direction_bits_q & ~taken;
    if (op_mode != P7IO_MODE_3) begin
      eff_oe[6] = 1'b1;
      eff_oe[5] = 1'b1;
    end
  end

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      read_mux[k] = pin_direction_bits_q[k] ? output_latch_q[k]
                                           : pin_lvl_q[k];
    end
  end

  // neighbour read bits 7..4; bits 3..0 are its own registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neighbour_read_hi <= 8'h00;
    end else begin
      neighbour_read_hi[7] <= key_mask_select_q[3] ? 1'b1
                                                   : read_mux[3];
      for (int m = 0; m < 3; m++) begin
        neighbour_read_hi[4+m] <= key_mask_select_q[m] ? nlvl_q[m+2]
                                                       : read_mux[m];
      end
      neighbour_read_hi[3:0] <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out             <= 8'h00;
      pin_oe              <= 8'h00;
      pullup_on           <= 8'h00;
      neighbour_pullup_on <= 4'h0;
      neighbour_pin0_out  <= 1'b0;
      neighbour_pin0_oe   <= 1'b0;
    end else begin
      pin_out <= eff_out;
      pin_oe  <= eff_oe;
      pullup_on <= {4'h0, pullup_enable_bits_q[7:4]
                          & ~pin_direction_bits_q[3:0]};
      neighbour_pullup_on[0] <= pullup_enable_bits_q[0]
                                & ~neighbour_direction_bits_q;
      neighbour_pullup_on[3:1] <= 3'h0;
      neighbour_pin0_out <= neighbour_latch_q;
      neighbour_pin0_oe  <= neighbour_direction_bits_q;
    end
  end

  // function inputs follow the synced pins; key sense stays live both ways
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_wait_in        <= 1'b0;
      host_addr_bit      <= 1'b0;
      host_read_strobe   <= 1'b0;
      host_write_strobe  <= 1'b0;
      timer_ext_clock_in <= 1'b0;
      key_sense_in       <= 1'b0;
    end else begin
      bus_wait_in <= (op_mode != P7IO_MODE_3) && wait_pin_used
                     && pin_lvl_q[7];
      host_addr_bit     <= taken[7] && op_mode == P7IO_MODE_3
                           && pin_lvl_q[7];
      host_read_strobe  <= taken[6] && op_mode == P7IO_MODE_3
                           && pin_lvl_q[6];
      host_write_strobe <= taken[5] && op_mode == P7IO_MODE_3
                           && pin_lvl_q[5];
      timer_ext_clock_in <= ext_clk_sel && nlvl_q[0];
      key_sense_in       <= nlvl_q[0];
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      `P7IO_OFF_DIR:    rdata_d = {24'h0, `P7IO_RD_ONES};
      `P7IO_OFF_LATCH:  rdata_d = {24'h0, read_mux};
      `P7IO_OFF_PULLUP: rdata_d = {24'h0, pullup_enable_bits_q};
      `P7IO_OFF_CTRL:   rdata_d = {24'h0, key_mask_select_q, 2'b00,
                                   neighbour_latch_q,
                                   neighbour_direction_bits_q};
      `P7IO_OFF_STAT:   rdata_d = {16'h0, nlvl_q[0], 7'h00, pin_lvl_q};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  // one wait state: answer in the second access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rdata_d;
      pslverr <= psel && penable && !pready
                 && !(paddr inside {`P7IO_OFF_DIR, `P7IO_OFF_LATCH,
                      `P7IO_OFF_PULLUP, `P7IO_OFF_CTRL, `P7IO_OFF_STAT});
    end
  end

  chk_dir_reads_ones: assert property (
    psel && penable && !pwrite && !pready && paddr == `P7IO_OFF_DIR
    |=> prdata[7:0] == 8'hFF) else $error("direction read not all ones");
  chk_dir_hw_clear: assert property (
    hw_standby |=> pin_direction_bits_q == 8'h00)
    else $error("direction not cleared");
  chk_latch_hw_clear: assert property (
    hw_standby |=> output_latch_q == 8'h00) else $error("latch not cleared");
  chk_pullup_gate: assert property (
    ##1 pullup_on[0] |-> $past(pullup_enable_bits_q[4])
    && !$past(pin_direction_bits_q[0])) else $error("pullup on wrongly");
  chk_mask_bit7: assert property (
    key_mask_select_q[3] |=> neighbour_read_hi[7])
    else $error("bit 7 not one");
  chk_strobe_drive: assert property (
    op_mode == P7IO_MODE_1 |=> pin_oe[6] && pin_oe[5])
    else $error("strobes not driven");
  chk_slave_taken: assert property (
    op_mode == P7IO_MODE_3 && slave_mode |=> pin_oe[7:5] == 3'b000)
    else $error("slave pins driven");
  chk_out_dir: assert property (
    op_mode == P7IO_MODE_3 && !slave_mode
    |=> pin_oe == $past(pin_direction_bits_q))
    else $error("oe not from direction");
  chk_timer_gate: assert property (
    !ext_clk_sel |=> !timer_ext_clock_in) else $error("timer clock leaked");
  cov_dir_write: cover property (wr_en && paddr == `P7IO_OFF_DIR);
  cov_mask_route: cover property (!key_mask_select_q[0]);
  cov_slave: cover property (slave_mode && op_mode == P7IO_MODE_3);
endmodule

// ==== verif/p7io_pins_model.sv ====
// Purpose: outside world of the port pads, resolves each pad level
// Assumes: a pad the port drives wins over anything outside
// Notes:   released pads with no outside drive or pull-up toggle every cycle, so the port's sync keeps its last settled level for them
`timescale 1ns/10ps
module p7io_pins_model (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic       n0_out,
  input  wire logic       n0_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  input  wire logic [4:0] nb_val,
  output logic      [7:0] pin_in,
  output logic      [3:0] neighbour_pin_in,
  output logic            neighbour_pin0_in
);
  logic [7:0] float_q = 8'h55;
  // no keeper on a floating pad: level changes every cycle
  always_ff @(posedge pclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] :
                  pullup_on[i] ? 1'b1 : float_q[i];
    end
  end
  assign neighbour_pin_in  = nb_val[3:0];
  assign neighbour_pin0_in = n0_oe ? n0_out : nb_val[4];
endmodule

// ==== verif/tb.sv ====
// Purpose: self-checking bench of the port block over APB
// Assumes: design answers with pready, pads settle within 8 cycles
// Notes:   random stimulus from a fixed xorshift seed
`timescale 1ns/10ps
`include "p7io_cfg.svh"
module tb
  import p7io_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rng = 40240;
  logic        pready, pslverr, hw_standby = 0, slave_mode = 0;
  logic        wait_pin_used = 0, bus_rd_strobe_n = 1, bus_wr_strobe_n = 1;
  logic        timer_clock_select_hi = 0, timer_clock_select_lo = 0;
  p7io_mode_t  op_mode = P7IO_MODE_3;
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_on, neighbour_read_hi;
  logic [7:0]  ext_val = 0, ext_drv = 8'hFF;
  logic [4:0]  nb_val = 0;
  logic [3:0]  neighbour_pin_in, neighbour_pullup_on;
  logic        neighbour_pin0_in, neighbour_pin0_out, neighbour_pin0_oe;
  logic        bus_wait_in, host_addr_bit, host_read_strobe;
  logic        host_write_strobe, timer_ext_clock_in, key_sense_in;
  int          mismatches = 0, checked = 0;

  always #10 pclk = ~pclk;

  p7io_port u_p7io_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hw_standby, .op_mode, .slave_mode,
    .wait_pin_used, .bus_rd_strobe_n, .bus_wr_strobe_n,
    .timer_clock_select_hi, .timer_clock_select_lo, .pin_in,
    .neighbour_pin_in, .neighbour_pin0_in, .pin_out, .pin_oe, .pullup_on,
    .neighbour_pullup_on, .neighbour_pin0_out, .neighbour_pin0_oe,
    .neighbour_read_hi, .bus_wait_in, .host_addr_bit, .host_read_strobe,
    .host_write_strobe, .timer_ext_clock_in, .key_sense_in);

  p7io_pins_model u_p7io_pins_model (.pclk, .pin_out, .pin_oe, .pullup_on,
    .n0_out(neighbour_pin0_out), .n0_oe(neighbour_pin0_oe), .ext_val,
    .ext_drv, .nb_val, .pin_in, .neighbour_pin_in, .neighbour_pin0_in);

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(logic wr, logic [17:0] a, logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(logic [17:0] a, logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rreg(logic [17:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 8'h00, r, e);
  endtask

  // pads pass a 3-flop sync and a register stage
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end

  initial begin
    logic [31:0] r;
    logic        e, lvl;
    logic [7:0]  dir, lat, pu, ctl, pins;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rreg(`P7IO_OFF_DIR, r);
    chk("dir read", r, 32'h0000_00FF);
    rreg(`P7IO_OFF_PULLUP, r);
    chk("pullup reset", r, 32'h0);
    chk("oe reset", pin_oe, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[7:0];
      lat = r[15:8];
      pu  = r[23:16];
      ctl = r[31:24];
      r = xs();
      ext_val <= r[7:0];
      ext_drv <= ~{4'h0, pu[7:4] & ~dir[3:0]};
      nb_val  <= r[12:8];
      timer_clock_select_hi <= r[13];
      timer_clock_select_lo <= r[14];
      wreg(`P7IO_OFF_DIR, dir);
      wreg(`P7IO_OFF_LATCH, lat);
      wreg(`P7IO_OFF_PULLUP, pu);
      wreg(`P7IO_OFF_CTRL, ctl);
      settle();
      pins = (dir & lat) | (~dir & (ext_val | ~ext_drv));
      rreg(`P7IO_OFF_LATCH, r);
      chk("data read", r, {24'h0, (lat & dir) | (pins & ~dir)});
      chk("pin oe", pin_oe, dir);
      chk("pin out", pin_out & dir, lat & dir);
      rreg(`P7IO_OFF_PULLUP, r);
      chk("pullup read", r, {24'h0, pu});
      chk("pullup on", pullup_on, {4'h0, pu[7:4] & ~dir[3:0]});
      chk("nb pullup", neighbour_pullup_on[0], pu[0] & ~ctl[0]);
      chk("nb0 oe", neighbour_pin0_oe, ctl[0]);
      chk("nb0 out", neighbour_pin0_out, ctl[1]);
      lvl = ctl[0] ? ctl[1] : nb_val[4];
      chk("key sense", key_sense_in, lvl);
      chk("timer clk", timer_ext_clock_in, timer_clock_select_hi &
          timer_clock_select_lo & lvl);
      chk("nb read 7", neighbour_read_hi[7], ctl[7] | pins[3]);
      for (int m = 4; m < 7; m++)
        if (!ctl[m])
          chk("nb read", neighbour_read_hi[m], pins[m-4]);
        else
          chk("nb read own", neighbour_read_hi[m], nb_val[m-3]);
    end
    ext_drv <= 8'hFF;
    wreg(`P7IO_OFF_DIR, 8'hFF);
    for (int k = 0; k < 5; k++) begin
      r = xs();
      op_mode <= (k < 2) ? P7IO_MODE_1 : (k < 4) ? P7IO_MODE_2 : P7IO_MODE_3;
      wait_pin_used   <= k[0];
      slave_mode      <= (k == 4);
      bus_rd_strobe_n <= r[0];
      bus_wr_strobe_n <= r[1];
      ext_val         <= r[15:8];
      settle();
      if (k < 4) begin
        chk("strobe oe", pin_oe[6:5], 2'b11);
        chk("strobe out", pin_out[6:5],
            {bus_rd_strobe_n, bus_wr_strobe_n});
        chk("pin7 oe", pin_oe[7], !wait_pin_used);
        if (wait_pin_used)
          chk("wait in", bus_wait_in, ext_val[7]);
      end else begin
        chk("host oe", pin_oe[7:5], 3'b000);
        chk("host pins", {host_addr_bit, host_read_strobe,
            host_write_strobe}, ext_val[7:5]);
      end
    end
    op_mode    <= P7IO_MODE_3;
    slave_mode <= 1'b0;
    wreg(`P7IO_OFF_PULLUP, 8'hFF);
    hw_standby <= 1'b1;
    repeat (3) @(posedge pclk);
    hw_standby <= 1'b0;
    settle();
    chk("oe standby", pin_oe, 8'h00);
    rreg(`P7IO_OFF_PULLUP, r);
    chk("pullup standby", r, 32'h0);
    wreg(`P7IO_OFF_DIR, 8'hFF);
    rreg(`P7IO_OFF_LATCH, r);
    chk("latch standby", r, 32'h0);
    apb(1'b0, 18'h00000, 8'h00, r, e);
    chk("unmapped err", e, 1'b1);
    end_sim();
  end
endmodule
